// [rtl/ubv_map.svh]
`ifndef UBV_MAP_SVH
`define UBV_MAP_SVH
// Setup packet framing
`define UBV_SETUP_BYTES      4'd8
`define UBV_VENDOR_OUT_TYPE  8'h40
// Request codes
`define UBV_QUERY_CPU_IDENTITY        8'h00
`define UBV_LOAD_TRANSFER_ADDRESS     8'h01
`define UBV_LOAD_TRANSFER_BYTE_COUNT  8'h02
`define UBV_FLUSH_BOTH_CACHES         8'h03
`define UBV_START_FROM_CACHE_COPY     8'h04
`define UBV_START_BY_DIRECT_BRANCH    8'h05
// Data stage of the identity query
`define UBV_CPU_INFO_BYTES   16'h0008
// Endpoint packet sizes in bytes
`define UBV_EP0_MPS          11'h040
`define UBV_BULK_MPS_HS      11'h200
`define UBV_BULK_MPS_FS      11'h040
// Reset values
`define UBV_ADDR_RST         32'h0000_0000
`define UBV_LEN_RST          32'h0000_0000
`endif

// [rtl/ubv_pkg.sv]
package ubv_pkg;
  typedef enum logic [2:0] {
    UBV_COLLECT,
    UBV_DECODE,
    UBV_INFO,
    UBV_COPY
  } ubv_state_e;

  // Setup packet, byte 0 in the low bits
  typedef struct packed {
    logic [15:0] length;
    logic [15:0] index;
    logic [15:0] value;
    logic [7:0]  request;
    logic [7:0]  req_type;
  } ubv_setup_s;
endpackage : ubv_pkg

// [rtl/ubv_decoder.sv]
`timescale 1ns/1ns
`include "ubv_map.svh"
// Overview of operation
// - Match request type 0x40 on every request
// - Code 0x00 with length 8 sends eight CPU identity bytes
// - Code 0x01 latches address, value high half
// - Code 0x02 latches byte count, value high
// - Code 0x03 flushes instruction and data caches
// - Code 0x04 copies cache, then starts program
// - Code 0x05 branches directly to entry point
// - EP0 64 bytes; bulk 512 HS, 64 FS
module ubv_decoder
  import ubv_pkg::*;
#(
  // Arbitrary identity value
  parameter logic [63:0] CPU_INFO = 64'h0123_4567_89ab_cdef
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Setup byte stream from endpoint 0
  input  wire logic        SETUP_VALID_I,
  input  wire logic [7:0]  SETUP_DATA_I,
  output logic             SETUP_READY_O,
  // Identity data stage
  output logic             IN_VALID_O,
  output logic [7:0]       IN_DATA_O,
  input  wire logic        IN_READY_I,
  // Request outcome
  output logic             ACK_O,
  output logic             STALL_O,
  // Bulk transfer setup
  output logic [31:0]      XFER_ADDR_O,
  output logic [31:0]      XFER_LEN_O,
  // Cache control
  output logic             ICACHE_FLUSH_O,
  output logic             DCACHE_FLUSH_O,
  output logic             COPY_REQ_O,
  input  wire logic        COPY_DONE_I,
  // Program start
  output logic             START_O,
  output logic             DIRECT_BRANCH_O,
  output logic [31:0]      ENTRY_O,
  // Packet sizes
  input  wire logic        HIGH_SPEED_I,
  output logic [10:0]      EP0_MPS_O,
  output logic [10:0]      BULK_MPS_O
);

  ubv_state_e  state;
  ubv_state_e  next_state;
  logic [63:0] pkt;
  logic [2:0]  byte_cnt;
  logic [2:0]  info_idx;
  logic [63:0] info_sr;
  ubv_setup_s  setup;
  logic        type_ok;
  logic        in_beat;
  logic        go_addr;
  logic        go_len;
  logic        go_flush;
  logic        go_info;
  logic        go_copy;
  logic        go_direct;
  logic        go_stall;

  assign setup   = ubv_setup_s'(pkt);
  assign in_beat = IN_VALID_O && IN_READY_I;
  assign type_ok = (state == UBV_DECODE) && (setup.req_type == `UBV_VENDOR_OUT_TYPE);

  assign go_info   = type_ok && (setup.request == `UBV_QUERY_CPU_IDENTITY)
                     && (setup.length == `UBV_CPU_INFO_BYTES);
  assign go_addr   = type_ok && (setup.request == `UBV_LOAD_TRANSFER_ADDRESS);
  assign go_len    = type_ok && (setup.request == `UBV_LOAD_TRANSFER_BYTE_COUNT);
  assign go_flush  = type_ok && (setup.request == `UBV_FLUSH_BOTH_CACHES);
  assign go_copy   = type_ok && (setup.request == `UBV_START_FROM_CACHE_COPY);
  assign go_direct = type_ok && (setup.request == `UBV_START_BY_DIRECT_BRANCH);
  assign go_stall  = type_ok && !(go_info || go_addr || go_len || go_flush || go_copy || go_direct);

  assign SETUP_READY_O = (state == UBV_COLLECT);
  assign IN_VALID_O    = (state == UBV_INFO);
  assign IN_DATA_O     = info_sr[7:0];
  assign COPY_REQ_O    = (state == UBV_COPY);

  assign EP0_MPS_O  = `UBV_EP0_MPS;
  assign BULK_MPS_O = HIGH_SPEED_I ? `UBV_BULK_MPS_HS : `UBV_BULK_MPS_FS;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    unique case (state)
      UBV_COLLECT: begin
        if (SETUP_VALID_I && byte_cnt == 3'h7) begin
          next_state = UBV_DECODE;
        end
      end
      UBV_DECODE: begin
        if (go_info) begin
          next_state = UBV_INFO;
        end else if (go_copy) begin
          next_state = UBV_COPY;
        end else begin
          next_state = UBV_COLLECT;
        end
      end
      UBV_INFO: begin
        if (in_beat && info_idx == 3'h7) begin
          next_state = UBV_COLLECT;
        end
      end
      UBV_COPY: begin
        if (COPY_DONE_I) begin
          next_state = UBV_COLLECT;
        end
      end
      default: next_state = UBV_COLLECT;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= UBV_COLLECT;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup bytes arrive low byte first
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pkt      <= 64'h0;
      byte_cnt <= 3'h0;
    end else if (SETUP_READY_O && SETUP_VALID_I) begin
      pkt      <= {SETUP_DATA_I, pkt[63:8]};
      byte_cnt <= byte_cnt + 3'h1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      info_sr  <= 64'h0;
      info_idx <= 3'h0;
    end else if (go_info) begin
      info_sr  <= CPU_INFO;
      info_idx <= 3'h0;
    end else if (in_beat) begin
      info_sr  <= {8'h00, info_sr[63:8]};
      info_idx <= info_idx + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address latch
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      XFER_ADDR_O <= `UBV_ADDR_RST;
    end else if (go_addr) begin
      XFER_ADDR_O <= {setup.value, setup.index};
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      XFER_LEN_O <= `UBV_LEN_RST;
    end else if (go_len) begin
      XFER_LEN_O <= {setup.value, setup.index};
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ICACHE_FLUSH_O <= 1'b0;
      DCACHE_FLUSH_O <= 1'b0;
    end else begin
      ICACHE_FLUSH_O <= go_flush;
      DCACHE_FLUSH_O <= go_flush;
    end
  end

  // Entry point held until the copy finishes
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ENTRY_O <= 32'h0;
    end else if (go_copy || go_direct) begin
      ENTRY_O <= {setup.value, setup.index};
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      START_O         <= 1'b0;
      DIRECT_BRANCH_O <= 1'b0;
    end else begin
      START_O         <= go_direct || (COPY_REQ_O && COPY_DONE_I);
      DIRECT_BRANCH_O <= go_direct;
    end
  end

  // Completion or stall of each vendor request; other request types get neither
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ACK_O   <= 1'b0;
      STALL_O <= 1'b0;
    end else begin
      ACK_O   <= go_addr || go_len || go_flush || go_direct || (COPY_REQ_O && COPY_DONE_I)
                 || (in_beat && info_idx == 3'h7);
      // Bad identity length also stalls, the data stage cannot be served
      STALL_O <= go_stall || (type_ok && setup.request == `UBV_QUERY_CPU_IDENTITY && !go_info);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  type_gate_a: assert property (state == UBV_DECODE && !type_ok |=> !ACK_O && !STALL_O && !START_O)
    else $error("Non vendor setup acted upon");
  info_len_a: assert property (go_info |=> IN_VALID_O && IN_DATA_O == CPU_INFO[7:0] && !ACK_O)
    else $error("Identity stage not started");
  info_end_a: assert property (in_beat && info_idx == 3'h7 |=> ACK_O && !IN_VALID_O)
    else $error("Identity stage not ended after eight bytes");
  addr_load_a: assert property (go_addr |=> XFER_ADDR_O == {$past(setup.value), $past(setup.index)} && ACK_O)
    else $error("Address not latched");
  len_load_a: assert property (go_len |=> XFER_LEN_O == {$past(setup.value), $past(setup.index)} && ACK_O)
    else $error("Byte count not latched");
  flush_both_a: assert property (go_flush |=> ICACHE_FLUSH_O && DCACHE_FLUSH_O ##1 !ICACHE_FLUSH_O)
    else $error("Cache flush pulse wrong");
  copy_start_a: assert property (go_copy |=> COPY_REQ_O && !START_O)
    else $error("Started before cache copy");
  // Done may come in the first copy cycle, so hold is checked per cycle
  copy_hold_a: assert property (COPY_REQ_O && !COPY_DONE_I |=> COPY_REQ_O && !START_O && !ACK_O)
    else $error("Copy request dropped or start before done");
  copy_done_a: assert property (COPY_REQ_O && COPY_DONE_I |=> START_O && !DIRECT_BRANCH_O && ACK_O)
    else $error("Copy completion did not start program");
  direct_go_a: assert property (go_direct |=> START_O && DIRECT_BRANCH_O
                                && ENTRY_O == {$past(setup.value), $past(setup.index)})
    else $error("Direct branch wrong");
  bulk_mps_a: assert property (BULK_MPS_O == (HIGH_SPEED_I ? 11'h200 : 11'h040) && EP0_MPS_O == 11'h040)
    else $error("Packet size wrong");
  stall_keep_a: assert property (go_stall |=> STALL_O && $stable(XFER_ADDR_O) && $stable(XFER_LEN_O))
    else $error("Unknown request not stalled");

  info_c: cover property (in_beat && info_idx == 3'h7);
  copy_c: cover property (COPY_REQ_O && COPY_DONE_I);
  direct_c: cover property (go_direct);
  stall_c: cover property (go_stall);

endmodule : ubv_decoder

// [verification/ubv_host_model.sv]
`timescale 1ns/1ns
module ubv_host_model
  import ubv_pkg::*;
(
  // Clock and pace
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  // Setup stream
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [7:0]       data_o,
  // Identity stage
  input  wire logic        in_valid_i,
  input  wire logic [7:0]  in_data_i,
  output logic             in_ready_o,
  output logic [63:0]      info_o
);
  logic rdy_n;
  initial begin
    valid_o = 1'b0;
    data_o = 8'h5a;
    in_ready_o = 1'b0;
    info_o = 64'h0;
    rdy_n = 1'b0;
  end
  // Mid-cycle copy, so a start never races the edge
  always @(negedge clk_i) rdy_n <= ready_i;
  task automatic send(input ubv_setup_s p);
    logic [63:0] b;
    b = p;
    while (!rdy_n) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      valid_o <= 1'b1;
      data_o  <= b[8*i +: 8];
      @(posedge clk_i);
    end
    valid_o <= 1'b0;
    // Released line shows inverse, not a stale byte
    data_o  <= ~b[63:56];
  endtask : send
  // Eight identity beats, slow host stalls
  always @(posedge clk_i) begin
    in_ready_o <= slow_i ? ~in_ready_o : 1'b1;
    if (in_valid_i && in_ready_o) info_o <= {in_data_i, info_o[63:8]};
  end
endmodule : ubv_host_model

// [verification/usb_boot_vendor_request_decoder_test.sv]
`timescale 1ns/1ns
module usb_boot_vendor_request_decoder_test
  import ubv_pkg::*;
();
  typedef struct packed {
    ubv_setup_s p;
    logic [31:0] a;
    logic [31:0] l;
    logic [2:0] e;
  } ubv_row_s;
  localparam logic [63:0] INFO = 64'h8877_6655_4433_2211;
  localparam ubv_row_s ROWS [6] = '{
    {64'h0000_5678_1234_0140, 32'h1234_5678, 32'h0, 3'b100},
    {64'h0000_cdef_00ab_0240, 32'h1234_5678, 32'h00ab_cdef, 3'b100},
    {64'h0000_ffff_ffff_0640, 32'h1234_5678, 32'h00ab_cdef, 3'b010},
    {64'h0000_0000_0000_0340, 32'h1234_5678, 32'h00ab_cdef, 3'b101},
    {64'h0000_beef_dead_01c0, 32'h1234_5678, 32'h00ab_cdef, 3'b000},
    {64'h0000_0000_0000_ff40, 32'h1234_5678, 32'h00ab_cdef, 3'b010}};
  logic clk = 0, rst_b = 0, sv, sr, iv, ir, ack, stall, ifl, dfl, creq, cdone = 0, st, db, hs = 0, slow = 0;
  logic [7:0] sd, id, n_ack = 0, n_st = 0, n_fl = 0, n_go = 0, n_dir = 0, b_ack, b_st, b_fl, b_go, b_dir;
  logic [31:0] xa, xl, ent, n_errors = 0, n_checks = 0, cyc = 0;
  logic [10:0] e0, bm;
  logic [63:0] info;
  ubv_decoder #(.CPU_INFO(INFO)) ubv_decoder_inst (.CLK_I(clk), .RST_B_I(rst_b),
    .SETUP_VALID_I(sv), .SETUP_DATA_I(sd), .SETUP_READY_O(sr), .IN_VALID_O(iv), .IN_DATA_O(id),
    .IN_READY_I(ir), .ACK_O(ack), .STALL_O(stall), .XFER_ADDR_O(xa), .XFER_LEN_O(xl),
    .ICACHE_FLUSH_O(ifl), .DCACHE_FLUSH_O(dfl), .COPY_REQ_O(creq), .COPY_DONE_I(cdone),
    .START_O(st), .DIRECT_BRANCH_O(db), .ENTRY_O(ent), .HIGH_SPEED_I(hs), .EP0_MPS_O(e0), .BULK_MPS_O(bm));
  ubv_host_model ubv_host_model_inst (.clk_i(clk), .slow_i(slow), .ready_i(sr), .valid_o(sv),
    .data_o(sd), .in_valid_i(iv), .in_data_i(id), .in_ready_o(ir), .info_o(info));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    n_ack <= n_ack + ack;
    n_st  <= n_st + stall;
    n_fl  <= n_fl + (ifl & dfl);
    n_go  <= n_go + st;
    n_dir <= n_dir + (st & db);
    cyc   <= cyc + 1;
    // Whole run needs well under this
    if (cyc == 32'd4000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic run(input ubv_setup_s p);
    {b_ack, b_st, b_fl, b_go, b_dir} = {n_ack, n_st, n_fl, n_go, n_dir};
    ubv_host_model_inst.send(p);
    repeat (6) @(posedge clk);
  endtask : run
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks != 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    cmp(xa, 32'h0);
    cmp(xl, 32'h0);
    cmp({31'h0, sr}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      run(ROWS[i].p);
      cmp(xa, ROWS[i].a);
      cmp(xl, ROWS[i].l);
      cmp({n_ack - b_ack, n_st - b_st, n_fl - b_fl}, {5'h0, ROWS[i].e[2], 7'h0, ROWS[i].e[1], 7'h0, ROWS[i].e[0]});
    end
    // Identity query against a stalling host
    slow <= 1'b1;
    run(64'h0008_0000_0000_0040);
    repeat (30) @(posedge clk);
    cmp(info[63:32], INFO[63:32]);
    cmp(info[31:0], INFO[31:0]);
    cmp({n_ack - b_ack, n_st - b_st}, 16'h0100);
    run(64'h0004_0000_0000_0040);
    cmp({n_ack - b_ack, n_st - b_st}, 16'h0001);
    // Copy held open by a late done
    run(64'h0000_0040_8000_0440);
    cmp({31'h0, creq}, 32'h1);
    cmp(n_go - b_go, 32'h0);
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({n_go - b_go, n_dir - b_dir, n_ack - b_ack}, 32'h010001);
    cmp(ent, 32'h8000_0040);
    run(64'h0000_1000_9000_0540);
    cmp({n_go - b_go, n_dir - b_dir, n_ack - b_ack}, 32'h010101);
    cmp(ent, 32'h9000_1000);
    cmp(xa, 32'h1234_5678);
    hs <= 1'b1;
    repeat (2) @(posedge clk);
    cmp({21'h0, bm}, 32'h200);
    hs <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({10'h0, bm, e0}, {10'h0, 11'h040, 11'h040});
    // Mid-run reset clears latches, first packet after release lands
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    cmp(xa, 32'h0);
    cmp(xl, 32'h0);
    cmp(ent, 32'h0);
    cmp({31'h0, sr}, 32'h1);
    rst_b <= 1'b1;
    run(ROWS[0].p);
    cmp(xa, ROWS[0].a);
    cmp(n_ack - b_ack, 32'h1);
    tally_and_finish();
  end
endmodule : usb_boot_vendor_request_decoder_test
